// ==== scmp_parser.sv ====
// serial control message receiver, checker and replier for one serial link
`timescale 1ns/100ps
`default_nettype none

module scmp_parser #(
  parameter int BIT_CYCLES = scmp_pkg::BIT_CYCLES_DEF,
  parameter int MAX_PAYLOAD = scmp_pkg::MAX_LEN_DEF
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rx_line,
  input wire logic cfg_addr_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic cmd_done,
  input wire logic cmd_ok,
  input wire logic [6:0] cmd_rd_index,
  output logic tx_line,
  output logic cmd_valid,
  output logic [23:0] cmd_code,
  output logic [7:0] cmd_len,
  output logic [7:0] cmd_rd_data,
  output logic [7:0] own_addr,
  output logic busy
);
  import scmp_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);
  localparam logic [3:0] RX_STOP = 4'(DATA_BITS + 1);
  localparam logic [3:0] TX_SPAN = 4'(CHAR_BITS);
  localparam logic [7:0] LEN_MAX = 8'(MAX_PAYLOAD);

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rx_prev;
  logic rx_act;
  logic [CW-1:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_vld;
  logic [7:0] rx_byte;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_prev <= 1'b1;
      rx_act <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_vld <= 1'b0;
      rx_byte <= 8'h00;
    end
    else
    begin
      rx_vld <= 1'b0;
      rx_prev <= rx_line;
      if (!rx_act)
      begin
        if (rx_prev && !rx_line)
        begin
          rx_act <= 1'b1;
          rx_cnt <= BIT_HALF;
          rx_bit <= 4'h0;
        end
      end
      else if (rx_cnt == '0)
      begin
        rx_cnt <= BIT_LAST;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0)
        begin
          // glitch shorter than half a bit is not a start
          if (rx_line)
            rx_act <= 1'b0;
        end
        else if (rx_bit < RX_STOP)
          rx_sh <= {rx_line, rx_sh[7:1]};
        else
        begin
          rx_act <= 1'b0;
          // bad stop bit drops the character
          if (rx_line)
          begin
            rx_vld <= 1'b1;
            rx_byte <= rx_sh;
          end
        end
      end
      else
        rx_cnt <= rx_cnt - 1'b1;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic tx_go;
  logic [7:0] tx_data;
  logic tx_busy;
  logic [8:0] tx_sh;
  logic [3:0] tx_left;
  logic [CW-1:0] tx_cnt;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_line <= 1'b1;
      tx_busy <= 1'b0;
      tx_sh <= 9'h1FF;
      tx_left <= 4'h0;
      tx_cnt <= '0;
    end
    else if (!tx_busy)
    begin
      if (tx_go)
      begin
        tx_line <= 1'b0;
        tx_sh <= {1'b1, tx_data};
        tx_left <= TX_SPAN;
        tx_cnt <= BIT_LAST;
        tx_busy <= 1'b1;
      end
    end
    else if (tx_cnt == '0)
    begin
      tx_cnt <= BIT_LAST;
      tx_left <= tx_left - 4'h1;
      if (tx_left == 4'h1)
        tx_busy <= 1'b0;
      else
      begin
        tx_line <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[8:1]};
      end
    end
    else
      tx_cnt <= tx_cnt - 1'b1;
  end

  // ----------------------------------------
  // message parser and reply sequencer
  // ----------------------------------------
  scmp_state_e state;
  logic [7:0] sum;
  logic [6:0] idx;
  logic addr_hit;
  logic bcast;
  logic echo;
  logic [7:0] reply_code;
  logic [WAIT_W-1:0] wait_bits;
  logic [CW-1:0] wait_cyc;
  logic [7:0] mem [0:MAX_PAYLOAD-1];
  logic [7:0] next_tx_byte;
  logic [6:0] last_pos;

  // reply delay in bit times; lower address answers sooner on broadcast
  function automatic logic [WAIT_W-1:0] reply_wait(input logic [7:0] addr, input logic bc,
                                                   input logic [7:0] nbytes);
    logic [WAIT_W-1:0] slot;
    slot = WAIT_W'(GAP_BITS) + WAIT_W'(nbytes) * WAIT_W'(CHAR_BITS);
    reply_wait = WAIT_W'(GAP_BITS);
    if (bc)
      reply_wait = reply_wait + WAIT_W'(addr) * slot;
  endfunction : reply_wait

  always_comb
  begin
    last_pos = echo ? (POS_DATA + cmd_len[6:0]) : POS_HCHK;
    if (idx == 7'h00)
      next_tx_byte = reply_code;
    else if (idx == POS_ADDR)
      next_tx_byte = own_addr;
    else if (idx < POS_LEN)
      next_tx_byte = cmd_code[8'(23 - 8 * (idx - 7'h02)) -: 8];
    else if (idx == POS_LEN)
      next_tx_byte = echo ? cmd_len : 8'h00;
    else if (idx == POS_HCHK || idx == last_pos)
      next_tx_byte = ~sum;
    else
      next_tx_byte = mem[idx - POS_DATA];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      own_addr <= ADDR_RESET;
    else if (cfg_addr_wr)
      own_addr <= cfg_addr;
  end

  always_ff @(posedge core_clk)
  begin
    if (state == S_DATA && rx_vld)
      mem[idx] <= rx_byte;
    cmd_rd_data <= (cmd_rd_index < 7'(MAX_PAYLOAD)) ? mem[cmd_rd_index] : 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state <= S_HUNT;
      sum <= 8'h00;
      idx <= 7'h00;
      addr_hit <= 1'b0;
      bcast <= 1'b0;
      echo <= 1'b0;
      reply_code <= CODE_NAK;
      wait_bits <= '0;
      wait_cyc <= '0;
      cmd_valid <= 1'b0;
      cmd_code <= 24'h000000;
      cmd_len <= 8'h00;
      tx_go <= 1'b0;
      tx_data <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      tx_go <= 1'b0;
      busy <= (state != S_HUNT);
      case (state)
        S_HUNT:
          // stray bytes, replies of others and the zero terminator fall here
          if (rx_vld && rx_byte == CODE_CMD)
          begin
            sum <= rx_byte;
            state <= S_ADDR;
          end
        S_ADDR:
          if (rx_vld)
          begin
            sum <= sum + rx_byte;
            bcast <= (rx_byte == ADDR_BCAST);
            addr_hit <= (rx_byte == ADDR_BCAST) || (rx_byte == own_addr);
            idx <= 7'h00;
            state <= S_CMD;
          end
        S_CMD:
          if (rx_vld)
          begin
            sum <= sum + rx_byte;
            cmd_code <= {cmd_code[15:0], rx_byte};
            idx <= idx + 7'h01;
            if (idx == 7'h02)
              state <= S_LEN;
          end
        S_LEN:
          if (rx_vld)
          begin
            sum <= sum + rx_byte;
            cmd_len <= rx_byte;
            state <= S_HCHK;
          end
        S_HCHK:
          if (rx_vld)
          begin
            reply_code <= CODE_NAK;
            echo <= 1'b0;
            wait_bits <= reply_wait(own_addr, bcast, 8'(HDR_BYTES));
            wait_cyc <= BIT_LAST;
            if (!addr_hit)
              state <= S_HUNT;
            else if (8'(sum + rx_byte) != SUM_OK)
              state <= S_GAP;
            else if (cmd_len > LEN_MAX)
              state <= S_GAP;
            else if (cmd_len == 8'h00)
            begin
              cmd_valid <= 1'b1;
              state <= S_EXEC;
            end
            else
            begin
              sum <= 8'h00;
              idx <= 7'h00;
              state <= S_DATA;
            end
          end
        S_DATA:
          if (rx_vld)
          begin
            sum <= sum + rx_byte;
            idx <= idx + 7'h01;
            if (idx == 7'(cmd_len - 8'h01))
              state <= S_DCHK;
          end
        S_DCHK:
          if (rx_vld)
          begin
            echo <= 1'b1;
            if (8'(sum + rx_byte) == SUM_OK)
            begin
              cmd_valid <= 1'b1;
              state <= S_EXEC;
            end
            else
            begin
              reply_code <= CODE_NAK;
              wait_bits <= reply_wait(own_addr, bcast, 8'(HDR_BYTES + 1) + cmd_len);
              wait_cyc <= BIT_LAST;
              state <= S_GAP;
            end
          end
        S_EXEC:
          // the gap is counted from command completion; a slow executor adds to it
          if (cmd_done)
          begin
            reply_code <= cmd_ok ? CODE_ACK : CODE_NAK;
            echo <= (cmd_len != 8'h00);
            wait_bits <= reply_wait(own_addr, bcast, (cmd_len != 8'h00)
                                    ? 8'(HDR_BYTES + 1) + cmd_len : 8'(HDR_BYTES));
            wait_cyc <= BIT_LAST;
            state <= S_GAP;
          end
        S_GAP:
          if (wait_cyc != '0)
            wait_cyc <= wait_cyc - 1'b1;
          else if (wait_bits == '0)
          begin
            sum <= 8'h00;
            idx <= 7'h00;
            state <= S_SEND;
          end
          else
          begin
            wait_cyc <= BIT_LAST;
            wait_bits <= wait_bits - 1'b1;
          end
        S_SEND:
          if (!tx_busy && !tx_go)
          begin
            tx_go <= 1'b1;
            tx_data <= next_tx_byte;
            sum <= (idx == POS_HCHK) ? 8'h00 : 8'(sum + next_tx_byte);
            idx <= idx + 7'h01;
            if (idx == last_pos)
              state <= S_DRAIN;
          end
        S_DRAIN:
          if (!tx_busy && !tx_go)
            state <= S_HUNT;
        default:
          state <= S_HUNT;
      endcase
    end
  end
endmodule : scmp_parser

`default_nettype wire

// ==== scmp_pkg.sv ====
// constants shared by the serial control message parser
package scmp_pkg;
  // ----------------------------------------
  // link timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD;
  localparam int DATA_BITS = 8;
  localparam int CHAR_BITS = 10;
  // base_reply_gap is 2.5 characters, widened by a jitter margin
  localparam int GAP_HALF_CHARS = 5;
  localparam int JITTER_BITS = 5;
  localparam int GAP_BITS = CHAR_BITS * GAP_HALF_CHARS / 2 + JITTER_BITS;
  // ----------------------------------------
  // message layout
  // ----------------------------------------
  localparam logic [7:0] CODE_CMD = 8'h07;
  localparam logic [7:0] CODE_ACK = 8'h06;
  localparam logic [7:0] CODE_NAK = 8'h15;
  localparam logic [7:0] ADDR_BCAST = 8'hFF;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] SUM_OK = 8'hFF;
  localparam int MAX_LEN_DEF = 74;
  localparam int HDR_BYTES = 7;
  localparam logic [6:0] POS_ADDR = 7'h01;
  localparam logic [6:0] POS_LEN = 7'h05;
  localparam logic [6:0] POS_HCHK = 7'h06;
  localparam logic [6:0] POS_DATA = 7'h07;
  localparam int WAIT_W = 20;
  typedef enum logic [3:0] {
    S_HUNT = 4'h0,
    S_ADDR = 4'h1,
    S_CMD = 4'h2,
    S_LEN = 4'h3,
    S_HCHK = 4'h4,
    S_DATA = 4'h5,
    S_DCHK = 4'h6,
    S_EXEC = 4'h7,
    S_GAP = 4'h8,
    S_SEND = 4'h9,
    S_DRAIN = 4'hA
  } scmp_state_e;
endpackage : scmp_pkg

// ==== scmp_parser_checker.sv ====
// port assertions for the serial control message parser
`timescale 1ns/100ps
`default_nettype none
module scmp_parser_checker #(
  parameter int MAX_PAYLOAD = 74
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_addr_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic tx_line,
  input wire logic cmd_valid,
  input wire logic [23:0] cmd_code,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] own_addr,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  rst_idle_a: assert property ($fell(sys_rst) |-> tx_line && !busy && own_addr == 8'h00)
    else $error("outputs not idle after reset");
  addr_load_a: assert property (cfg_addr_wr |=> own_addr == $past(cfg_addr))
    else $error("own address not loaded");
  addr_hold_a: assert property (!cfg_addr_wr |=> $stable(own_addr))
    else $error("own address changed unasked");
  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command valid longer than one cycle");
  valid_len_a: assert property (cmd_valid |-> busy && cmd_len <= MAX_PAYLOAD)
    else $error("command released with bad length");
  reply_wait_a: assert property (cmd_valid |=> tx_line [*8])
    else $error("reply started before the gap");
  tx_idle_a: assert property (!busy |-> tx_line)
    else $error("transmit active while hunting");
  code_hold_a: assert property (!busy |=> $stable(cmd_code) && $stable(cmd_len))
    else $error("command fields changed while idle");
  valid_cv: cover property (cmd_valid);
  reply_cv: cover property ($fell(tx_line));
  addr_cv: cover property (cfg_addr_wr);
endmodule : scmp_parser_checker
`default_nettype wire

// ==== scmp_host.sv ====
// host side serial model: sends frames, receives replies
`timescale 1ns/100ps
`default_nettype none
module scmp_host #(
  parameter int BC = 16
) (
  input wire logic core_clk,
  output logic rx_line,
  input wire logic tx_line
);
  initial rx_line = 1'b1;
  // lsb first, back to back; xon/xoff never interpreted
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_line <= f[i];
      repeat (BC) @(posedge core_clk);
    end
  endtask : send_byte
  // sample mid-bit; bounded wait of 20000 cycles covers reply gaps up to 1250 bit times at BC of 16
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    while (tx_line !== 1'b0 && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (BC + BC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = tx_line;
      repeat (BC) @(posedge core_clk);
    end
    ok = (n < 20000) && (tx_line === 1'b1);
  endtask : recv_byte
endmodule : scmp_host
`default_nettype wire

// ==== test_scmp_parser.sv ====
// self-checking bench for the serial control message parser
`timescale 1ns/100ps
`default_nettype none
module test_scmp_parser;
  import scmp_pkg::*;
  localparam int BC = 16;
  typedef logic [7:0] scmp_q_t[$];
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_addr_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic cmd_done = 1'b0;
  logic cmd_ok = 1'b0;
  logic [6:0] cmd_rd_index = 7'h00;
  logic rx_line, tx_line, cmd_valid, busy;
  logic [23:0] cmd_code;
  logic [7:0] cmd_len, cmd_rd_data, own_addr;
  int n_mismatch = 0;
  int checked = 0;
  int n_valid = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  scmp_parser #(.BIT_CYCLES(BC), .MAX_PAYLOAD(MAX_LEN_DEF)) scmp_parser_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .rx_line(rx_line), .cfg_addr_wr(cfg_addr_wr),
    .cfg_addr(cfg_addr), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .cmd_rd_index(cmd_rd_index),
    .tx_line(tx_line), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_len(cmd_len),
    .cmd_rd_data(cmd_rd_data), .own_addr(own_addr), .busy(busy));
  scmp_host #(.BC(BC)) scmp_host_inst (.core_clk(core_clk), .rx_line(rx_line), .tx_line(tx_line));
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1)
      n_valid <= n_valid + 1;
    if (cyc == 90000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  function automatic scmp_q_t frame(input logic [7:0] sc, input logic [7:0] ad,
    input logic [23:0] cd, input scmp_q_t pl, input logic [7:0] ln, input logic [7:0] hx,
    input logic [7:0] dx);
    scmp_q_t q;
    logic [7:0] s;
    q = {sc, ad, cd[23:16], cd[15:8], cd[7:0], ln};
    s = 8'h00;
    foreach (q[i])
      s += q[i];
    q.push_back(~s ^ hx);
    s = 8'h00;
    foreach (pl[i])
    begin
      q.push_back(pl[i]);
      s += pl[i];
    end
    if (pl.size() > 0)
      q.push_back(~s ^ dx);
    return q;
  endfunction : frame
  task automatic xfer(input scmp_q_t tx, input int nv, input logic ok, input scmp_q_t exp);
    logic [7:0] b;
    bit got;
    int v0;
    int n;
    n = 0;
    // five idle characters also let the last reply stop bit finish
    repeat (50 * BC) @(posedge core_clk);
    v0 = n_valid;
    foreach (tx[i])
      scmp_host_inst.send_byte(tx[i]);
    while (n_valid == v0 && nv > 0 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    if (nv > 0)
    begin
      cmp(cmd_code, {tx[2], tx[3], tx[4]});
      cmp(24'(cmd_len), 24'(tx[5]));
      for (int i = 0; i < tx[5]; i++)
      begin
        cmd_rd_index <= 7'(i);
        repeat (3) @(posedge core_clk);
        cmp(24'(cmd_rd_data), 24'(tx[7 + i]));
      end
      cmd_done <= 1'b1;
      cmd_ok <= ok;
      @(posedge core_clk);
      cmd_done <= 1'b0;
    end
    foreach (exp[i])
    begin
      scmp_host_inst.recv_byte(b, got);
      cmp({15'h0, got, b}, {16'h0001, exp[i]});
    end
    if (exp.size() == 0)
      repeat (1500)
      begin
        @(posedge core_clk);
        cmp(24'(tx_line), 24'h1);
      end
    cmp(24'(n_valid - v0), 24'(nv));
  endtask : xfer
  // reply start counted from the end of the last stop bit, rounded to whole bits;
  // the extra bit is the first bit count in S_GAP, taken before wait_bits starts counting down
  task automatic gap_xfer(input scmp_q_t tx, input int w, input scmp_q_t exp);
    logic [7:0] b;
    bit got;
    int n;
    n = 0;
    repeat (50 * BC) @(posedge core_clk);
    foreach (tx[i])
      scmp_host_inst.send_byte(tx[i]);
    while (tx_line !== 1'b0 && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    cmp(24'((n + BC / 2) / BC), 24'(w + 1));
    foreach (exp[i])
    begin
      scmp_host_inst.recv_byte(b, got);
      cmp({15'h0, got, b}, {16'h0001, exp[i]});
    end
  endtask : gap_xfer
  initial
  begin
    scmp_q_t e;
    scmp_q_t p;
    scmp_q_t m;
    scmp_q_t q;
    logic [23:0] c;
    c = 24'h425249;
    p = {8'h99, 8'h3C};
    for (int i = 0; i < MAX_LEN_DEF; i++)
      m.push_back(8'(i + 32));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    cmp(24'(own_addr), 24'h0);
    q = frame(CODE_CMD, ADDR_BCAST, c, e, 8'h00, 8'h00, 8'h00);
    q.push_back(8'h00);
    xfer(q, 1, 1'b1, frame(CODE_ACK, ADDR_RESET, c, e, 8'h00, 8'h00, 8'h00));
    cfg_addr <= 8'h05;
    cfg_addr_wr <= 1'b1;
    @(posedge core_clk);
    cfg_addr_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp(24'(own_addr), 24'h5);
    xfer(frame(CODE_CMD, 8'h05, c, p, 8'h02, 8'h00, 8'h00), 1, 1'b0,
      frame(CODE_NAK, 8'h05, c, p, 8'h02, 8'h00, 8'h00));
    xfer(frame(CODE_CMD, 8'h05, c, m, 8'h4A, 8'h00, 8'h00), 1, 1'b1,
      frame(CODE_ACK, 8'h05, c, m, 8'h4A, 8'h00, 8'h00));
    xfer(frame(CODE_CMD, 8'h05, c, e, 8'h00, 8'h01, 8'h00), 0, 1'b0,
      frame(CODE_NAK, 8'h05, c, e, 8'h00, 8'h00, 8'h00));
    xfer(frame(CODE_CMD, 8'h05, c, p, 8'h02, 8'h00, 8'h10), 0, 1'b0,
      frame(CODE_NAK, 8'h05, c, p, 8'h02, 8'h00, 8'h00));
    xfer(frame(CODE_CMD, 8'h05, c, e, 8'h4B, 8'h00, 8'h00), 0, 1'b0,
      frame(CODE_NAK, 8'h05, c, e, 8'h00, 8'h00, 8'h00));
    xfer(frame(CODE_CMD, 8'h06, c, e, 8'h00, 8'h00, 8'h00), 0, 1'b0, e);
    xfer(frame(CODE_ACK, 8'h05, c, e, 8'h00, 8'h00, 8'h00), 0, 1'b0, e);
    // unicast answer waits only the base gap
    gap_xfer(frame(CODE_CMD, 8'h05, c, e, 8'h00, 8'h01, 8'h00), GAP_BITS,
      frame(CODE_NAK, 8'h05, c, e, 8'h00, 8'h00, 8'h00));
    // broadcast answer waits one slot per address below its own
    gap_xfer(frame(CODE_CMD, ADDR_BCAST, c, e, 8'h00, 8'h01, 8'h00),
      GAP_BITS + 5 * (GAP_BITS + HDR_BYTES * CHAR_BITS),
      frame(CODE_NAK, 8'h05, c, e, 8'h00, 8'h00, 8'h00));
    finish_test();
  end
endmodule : test_scmp_parser
bind scmp_parser scmp_parser_checker #(.MAX_PAYLOAD(MAX_PAYLOAD)) scmp_parser_checker_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .cfg_addr_wr(cfg_addr_wr), .cfg_addr(cfg_addr),
  .tx_line(tx_line), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_len(cmd_len),
  .own_addr(own_addr), .busy(busy));
`default_nettype wire
